//--- verilog/rtu_pkg.sv
// Behaviour
// R1 - general timers pick 13.56M, 212k or wake-up underflow
// R2 - sixteen bit down-counter readable as two bytes
// R3 - reload value spans 0000h to FFFFh
// R4 - wake-up timer counts low-frequency oscillator ticks
// R5 - global control starts, stops, reports four timers
// R6 - running timer decrements once per selected tick
// R7 - at zero, next tick raises the timer interrupt
// R8 - underflow sets that timer's interrupt flag
// R9 - host may set or clear each flag
// R10 - at zero stop or reload per configuration
// R11 - running flag mirrors whether timer counts
// R12 - start: run plus immediate bit; stop: immediate only
// R13 - mode start bit also starts the timer
// R14 - time-out counts to zero then interrupts
// R15 - stop event halts count, value stays readable
// R16 - auto reload with interrupt gives periodic requests
// R17 - enabled timer interrupt drives the request pin
// R18 - global flag sets when any enabled flag sets
// R19 - without auto wake, stay powered after empty detect
// R20 - wake-up underflow leaves standby; may re-enter
// R21 - pin and status bit both show pending interrupts
// R22 - events and wake-up underflow are one-cycle pulses
// R23 - reload loads both counter bytes together
package rtu_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_GEN   = 4;   // general timers
  localparam int unsigned NUM_TMR   = 5;   // including wake-up timer
  localparam int unsigned WAKE_IDX  = 4;   // index of wake-up timer
  localparam int unsigned CNT_W     = 16;  // counter width

  // ---------------------------------------------------------------
  // reset value, decrement step and zero compare
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // global control write layout
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RUN_LSB = 0;  // running bits 3:0
  localparam int unsigned CTRL_NOW_LSB = 4;  // immediate bits 7:4

  // ---------------------------------------------------------------
  // flag write layout: bit 7 chooses set (1) or clear (0)
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_SETCLR_BIT = 7;

  // ---------------------------------------------------------------
  // count clock selection codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_13M56 = 2'h0;  // carrier clock ticks
  localparam logic [1:0] SEL_212K  = 2'h1;  // slow carrier ticks
  localparam logic [1:0] SEL_WAKE  = 2'h2;  // wake-up underflow

  // ---------------------------------------------------------------
  // power state, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RTU_AWAKE   = 2'b01,
    RTU_STANDBY = 2'b10
  } rtu_state_e;

  // ---------------------------------------------------------------
  // per general timer configuration
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  clk_sel;            // count clock selection
    logic        auto_reload_enable; // reload at zero
    logic        irq_enable;         // interrupt enable
    logic        start_on_tx;        // start on transmitter event
    logic        stop_on_rx;         // stop on receiver event
    logic [7:0]  reload_high_byte;   // reload value high
    logic [7:0]  reload_low_byte;    // reload value low
  } rtu_cfg_s;

endpackage

//--- verilog/rtu_down_counter.sv
`timescale 1ns/1ps
module rtu_down_counter (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // control
  input  wire logic              tick,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic              auto_reload_enable,
  input  wire logic [15:0]       reload_val,
  // state
  output logic [15:0]            count_ff,
  output logic                   running_ff,
  output logic                   underflow_ff
);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [15:0] nxt_count;     // next counter value
  logic        nxt_running;   // next running state
  logic        nxt_underflow; // next underflow pulse

  // counting, reload and stop decisions
  always_comb begin
    nxt_count     = count_ff;
    nxt_running   = running_ff;
    nxt_underflow = 1'b0;
    if (start) begin
      // both bytes load at once [R23] [R15]
      nxt_count   = reload_val;
      nxt_running = 1'b1;
    end else if (stop) begin
      // halt and keep value readable [R15]
      nxt_running = 1'b0;
    end else if (running_ff && tick) begin
      if (count_ff == rtu_pkg::COUNT_ZERO) begin
        // tick at zero is the underflow [R7] [R14]
        nxt_underflow = 1'b1;
        if (auto_reload_enable) begin
          nxt_count = reload_val; // periodic [R10] [R16] [R23]
        end else begin
          nxt_running = 1'b0;     // one shot ends [R10]
        end
      end else begin
        nxt_count = count_ff - rtu_pkg::COUNT_ONE; // [R6]
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_ff     <= rtu_pkg::COUNT_RST;
      running_ff   <= 1'b0;
      underflow_ff <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      running_ff   <= nxt_running;
      underflow_ff <= nxt_underflow;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_dec;
    @(posedge clk_sys) disable iff (rst)
    running_ff && tick && !start && !stop && count_ff != 16'h0000
    |=> count_ff == $past(count_ff) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement"); // [R6]

  property p_uf;
    @(posedge clk_sys) disable iff (rst)
    running_ff && tick && !start && !stop && count_ff == 16'h0000
    |=> underflow_ff ##1 !underflow_ff;
  endproperty
  a_uf: assert property (p_uf) else $error("no underflow"); // [R7]

  property p_reload;
    @(posedge clk_sys) disable iff (rst)
    running_ff && tick && !start && !stop && count_ff == 16'h0000
    |=> (running_ff == $past(auto_reload_enable)) &&
        (count_ff == ($past(auto_reload_enable) ?
                      $past(reload_val) : 16'h0000));
  endproperty
  a_reload: assert property (p_reload) else $error("bad reload"); // [R10]

  property p_halt;
    @(posedge clk_sys) disable iff (rst)
    stop && !start |=> !running_ff && count_ff == $past(count_ff);
  endproperty
  a_halt: assert property (p_halt) else $error("stop ignored"); // [R15]

endmodule

//--- verilog/rtu_timer_unit.sv
`timescale 1ns/1ps
module rtu_timer_unit (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // count clock tick pulses
  input  wire logic                     tick_13m56,
  input  wire logic                     tick_212k,
  input  wire logic                     tick_lfo,
  // general timer configuration
  input  wire rtu_pkg::rtu_cfg_s [3:0]  tmr_cfg,
  input  wire logic [3:0]               mode_start,
  // global control write
  input  wire logic                     ctrl_wr,
  input  wire logic [7:0]               ctrl_wdata,
  // interrupt flag write
  input  wire logic                     flag_wr,
  input  wire logic [7:0]               flag_wdata,
  input  wire logic                     global_clr,
  input  wire logic                     irq_pin_enable,
  // transceiver events
  input  wire logic                     tx_start_evt,
  input  wire logic                     rx_stop_evt,
  // wake-up timer control
  input  wire logic                     wake_start,
  input  wire logic                     wake_stop,
  input  wire logic [15:0]              wake_reload,
  input  wire logic                     wake_auto_reload_enable,
  input  wire logic                     auto_standby_wake,
  input  wire logic                     enter_standby,
  input  wire logic                     detect_no_card,
  // counters and status
  output logic [4:0][15:0]              count_value,
  output logic [3:0]                    timer_running,
  output logic [3:0]                    timer_irq_flag,
  output logic                          global_irq_flag,
  output logic                          irq_status,
  output logic                          irq_pin,
  output logic                          standby
);

  // ---------------------------------------------------------------
  // per timer wiring
  // ---------------------------------------------------------------
  logic [4:0]       tick_v;    // selected tick per timer
  logic [4:0]       start_v;   // start request per timer
  logic [4:0]       stop_v;    // stop request per timer
  logic [4:0]       auto_v;    // reload at zero per timer
  logic [4:0][15:0] reload_v;  // reload value per timer
  logic [4:0]       run_v;     // running state per timer
  logic [4:0]       uf_v;      // underflow pulse per timer
  logic [3:0]       en_v;      // interrupt enable per timer
  logic             wake_uf;   // wake-up timer underflow

  assign wake_uf = uf_v[rtu_pkg::WAKE_IDX];

  // ---------------------------------------------------------------
  // general timer request decode
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < rtu_pkg::NUM_GEN; g++) begin : g_gen
      // count clock selection [R1]
      assign tick_v[g] =
        (tmr_cfg[g].clk_sel == rtu_pkg::SEL_13M56) ? tick_13m56 :
        (tmr_cfg[g].clk_sel == rtu_pkg::SEL_212K)  ? tick_212k  :
        (tmr_cfg[g].clk_sel == rtu_pkg::SEL_WAKE)  ? wake_uf    :
        1'b0;
      // global start, mode start and transmitter start [R12] [R13]
      assign start_v[g] =
        (ctrl_wr && ctrl_wdata[rtu_pkg::CTRL_NOW_LSB + g] &&
         ctrl_wdata[rtu_pkg::CTRL_RUN_LSB + g]) ||
        mode_start[g] ||
        (tmr_cfg[g].start_on_tx && tx_start_evt);
      // global stop and receiver stop event [R12] [R5] [R15]
      assign stop_v[g] =
        (ctrl_wr && ctrl_wdata[rtu_pkg::CTRL_NOW_LSB + g] &&
         !ctrl_wdata[rtu_pkg::CTRL_RUN_LSB + g]) ||
        (tmr_cfg[g].stop_on_rx && rx_stop_evt);
      assign auto_v[g]   = tmr_cfg[g].auto_reload_enable;
      assign reload_v[g] = {tmr_cfg[g].reload_high_byte,
                            tmr_cfg[g].reload_low_byte}; // [R3]
      assign en_v[g]     = tmr_cfg[g].irq_enable;
    end
  endgenerate

  // wake-up timer runs only on oscillator ticks [R4]
  assign tick_v[rtu_pkg::WAKE_IDX]   = tick_lfo;
  assign start_v[rtu_pkg::WAKE_IDX]  = wake_start;
  assign stop_v[rtu_pkg::WAKE_IDX]   = wake_stop;
  assign auto_v[rtu_pkg::WAKE_IDX]   = wake_auto_reload_enable;
  assign reload_v[rtu_pkg::WAKE_IDX] = wake_reload;

  // ---------------------------------------------------------------
  // counters, one per timer
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < rtu_pkg::NUM_TMR; g++) begin : g_cnt
      // sixteen bit down-counter [R2]
      rtu_down_counter u_cnt (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .tick               (tick_v[g]),
        .start              (start_v[g]),
        .stop               (stop_v[g]),
        .auto_reload_enable (auto_v[g]),
        .reload_val         (reload_v[g]),
        .count_ff           (count_value[g]),
        .running_ff         (run_v[g]),
        .underflow_ff       (uf_v[g])
      );
    end
  endgenerate

  // running status straight from counter flops [R11] [R5]
  assign timer_running = run_v[3:0];

  // ---------------------------------------------------------------
  // interrupt flags
  // ---------------------------------------------------------------
  logic [3:0] flag_ff;       // per timer interrupt flags
  logic [3:0] nxt_flag;      // next flags
  logic       glob_ff;       // global interrupt flag
  logic       nxt_glob;      // next global flag
  logic       status_ff;     // pending enabled interrupt
  logic       nxt_status;    // next pending state
  logic       pin_ff;        // interrupt pin level
  logic       nxt_pin;       // next pin level
  logic [3:0] flag_rise;     // flags newly set this cycle

  // flag update: host write first, hardware set wins
  always_comb begin
    nxt_flag = flag_ff;
    if (flag_wr) begin
      if (flag_wdata[rtu_pkg::FLAG_SETCLR_BIT]) begin
        nxt_flag = flag_ff | flag_wdata[3:0];  // host set [R9]
      end else begin
        nxt_flag = flag_ff & ~flag_wdata[3:0]; // host clear [R9]
      end
    end
    nxt_flag   = nxt_flag | uf_v[3:0];          // underflow [R8]
    flag_rise  = nxt_flag & ~flag_ff;
    // global flag: any enabled flag setting wins over clear [R18]
    nxt_glob   = global_clr ? 1'b0 : glob_ff;
    if ((flag_rise & en_v) != 4'h0) begin
      nxt_glob = 1'b1;
    end
    // pending status and pin [R21] [R17] [R7]
    nxt_status = (nxt_flag & en_v) != 4'h0;
    nxt_pin    = irq_pin_enable && nxt_status;
  end

  // flag registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_ff   <= 4'h0;
      glob_ff   <= 1'b0;
      status_ff <= 1'b0;
      pin_ff    <= 1'b0;
    end else begin
      flag_ff   <= nxt_flag;
      glob_ff   <= nxt_glob;
      status_ff <= nxt_status;
      pin_ff    <= nxt_pin;
    end
  end

  assign timer_irq_flag  = flag_ff;
  assign global_irq_flag = glob_ff;
  assign irq_status      = status_ff;
  assign irq_pin         = pin_ff;

  // ---------------------------------------------------------------
  // standby control
  // ---------------------------------------------------------------
  rtu_pkg::rtu_state_e state_ff;    // power state
  rtu_pkg::rtu_state_e nxt_state;   // next power state
  logic                standby_ff;  // standby output
  logic                nxt_standby; // next standby output

  // wake on underflow, return on enter_standby or on empty detect with auto wake set
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rtu_pkg::RTU_AWAKE: begin
        // enter_standby, or empty detect with auto wake set, re-enters standby [R19] [R20]
        if (enter_standby ||
            (detect_no_card && auto_standby_wake)) begin
          nxt_state = rtu_pkg::RTU_STANDBY;
        end
      end
      rtu_pkg::RTU_STANDBY: begin
        // wake-up interval elapsed [R20] [R22]
        if (wake_uf) begin
          nxt_state = rtu_pkg::RTU_AWAKE;
        end
      end
      default: begin
        nxt_state = rtu_pkg::RTU_AWAKE;
      end
    endcase
    nxt_standby = (nxt_state == rtu_pkg::RTU_STANDBY);
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff   <= rtu_pkg::RTU_AWAKE;
      standby_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      standby_ff <= nxt_standby;
    end
  end

  assign standby = standby_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_flag_set;
    @(posedge clk_sys) disable iff (rst)
    uf_v[3:0] != 4'h0 |=>
      (flag_ff & $past(uf_v[3:0])) == $past(uf_v[3:0]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag lost"); // [R8]

  property p_flag_clr;
    @(posedge clk_sys) disable iff (rst)
    flag_wr && !flag_wdata[rtu_pkg::FLAG_SETCLR_BIT] && uf_v[3:0] == 4'h0 |=>
      (flag_ff & $past(flag_wdata[3:0])) == 4'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("no clear"); // [R9]

  property p_glob;
    @(posedge clk_sys) disable iff (rst)
    (uf_v[3:0] & en_v & ~flag_ff) != 4'h0 |=> global_irq_flag;
  endproperty
  a_glob: assert property (p_glob) else $error("global missing"); // [R18]

  property p_pin;
    @(posedge clk_sys) disable iff (rst)
    irq_pin |-> irq_status;
  endproperty
  a_pin: assert property (p_pin) else $error("pin without status"); // [R17]

  property p_start;
    @(posedge clk_sys) disable iff (rst)
    ctrl_wr && ctrl_wdata[4] && ctrl_wdata[0] |=> timer_running[0];
  endproperty
  a_start: assert property (p_start) else $error("not started"); // [R12]

  property p_stop;
    @(posedge clk_sys) disable iff (rst)
    ctrl_wr && ctrl_wdata[4] && !ctrl_wdata[0] && !mode_start[0] &&
    !(tmr_cfg[0].start_on_tx && tx_start_evt) |=> !timer_running[0];
  endproperty
  a_stop: assert property (p_stop) else $error("not stopped"); // [R11]

  property p_mode;
    @(posedge clk_sys) disable iff (rst)
    mode_start[1] |=> timer_running[1] [*1];
  endproperty
  a_mode: assert property (p_mode) else $error("mode start"); // [R13]

  property p_wake;
    @(posedge clk_sys) disable iff (rst)
    standby && wake_uf |=> !standby;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // [R20]

  property p_stay;
    @(posedge clk_sys) disable iff (rst)
    !standby && !enter_standby && !auto_standby_wake |=> !standby;
  endproperty
  a_stay: assert property (p_stay) else $error("left powered"); // [R19]

  property p_status;
    @(posedge clk_sys) disable iff (rst)
    irq_status == ((timer_irq_flag & $past(en_v)) != 4'h0);
  endproperty
  a_status: assert property (p_status) else $error("status wrong"); // [R21]

  property p_pin_off;
    @(posedge clk_sys) disable iff (rst)
    !irq_pin_enable |=> !irq_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin ungated"); // [R17]

  property p_enter;
    @(posedge clk_sys) disable iff (rst)
    !standby && enter_standby |=> standby;
  endproperty
  a_enter: assert property (p_enter) else $error("no standby"); // [R20]

  property p_wake_src;
    @(posedge clk_sys) disable iff (rst)
    !tick_lfo && !wake_start |=> count_value[4] == $past(count_value[4]);
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake moved"); // [R4]

  property p_glob_hold;
    @(posedge clk_sys) disable iff (rst)
    global_irq_flag && !global_clr |=> global_irq_flag;
  endproperty
  a_glob_hold: assert property (p_glob_hold) else $error("glob lost"); // [R18]

endmodule

//--- bench/rtu_timer_unit_tb.sv
`timescale 1ns/1ps
module rtu_timer_unit_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                    clk_sys;   // 100 MHz
  logic                    rst;       // sync, high
  logic                    tick_13m56, tick_212k, tick_lfo;
  rtu_pkg::rtu_cfg_s [3:0] tmr_cfg;   // per timer setup
  logic [3:0]              mode_start;
  logic                    ctrl_wr, flag_wr, global_clr;
  logic [7:0]              ctrl_wdata, flag_wdata;
  logic                    irq_pin_enable, tx_start_evt, rx_stop_evt;
  logic                    wake_start, wake_stop, wake_auto_reload_enable;
  logic [15:0]             wake_reload;
  logic                    auto_standby_wake, enter_standby;
  logic                    detect_no_card;
  logic [4:0][15:0]        count_value;
  logic [3:0]              timer_running, timer_irq_flag;
  logic                    global_irq_flag, irq_status, irq_pin;
  logic                    standby;
  int                      n_errors = 0;
  int                      compares = 0;
  // pulse selectors for the drive task
  localparam int CW = 0, FW = 1, T13 = 2, T212 = 3, LOW_FREQUENCY_OSCILLATOR = 4, MS = 5;
  localparam int TXE = 6, RXE = 7, WST = 8, ESB = 9, DNC = 10, GCL = 11;
  localparam int WSP = 12;

  rtu_timer_unit dut_u (.clk_sys(clk_sys), .rst(rst),
    .tick_13m56(tick_13m56), .tick_212k(tick_212k), .tick_lfo(tick_lfo),
    .tmr_cfg(tmr_cfg), .mode_start(mode_start), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .global_clr(global_clr), .irq_pin_enable(irq_pin_enable),
    .tx_start_evt(tx_start_evt), .rx_stop_evt(rx_stop_evt),
    .wake_start(wake_start), .wake_stop(wake_stop),
    .wake_reload(wake_reload),
    .wake_auto_reload_enable(wake_auto_reload_enable),
    .auto_standby_wake(auto_standby_wake),
    .enter_standby(enter_standby), .detect_no_card(detect_no_card),
    .count_value(count_value), .timer_running(timer_running),
    .timer_irq_flag(timer_irq_flag), .global_irq_flag(global_irq_flag),
    .irq_status(irq_status), .irq_pin(irq_pin), .standby(standby));

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and stop
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle pulse on a selected input, settled outputs on return
  task automatic drive(input int s, input logic [7:0] d);
    @(posedge clk_sys);
    case (s)
      CW:   begin ctrl_wr <= 1'b1; ctrl_wdata <= d; end
      FW:   begin flag_wr <= 1'b1; flag_wdata <= d; end
      T13:  tick_13m56 <= 1'b1;
      T212: tick_212k <= 1'b1;
      LOW_FREQUENCY_OSCILLATOR:  tick_lfo <= 1'b1;
      MS:   mode_start <= d[3:0];
      TXE:  tx_start_evt <= 1'b1;
      RXE:  rx_stop_evt <= 1'b1;
      WST:  wake_start <= 1'b1;
      ESB:  enter_standby <= 1'b1;
      DNC:  detect_no_card <= 1'b1;
      WSP:  wake_stop <= 1'b1;
      default: global_clr <= 1'b1;
    endcase
    @(posedge clk_sys);
    {ctrl_wr, flag_wr, tick_13m56, tick_212k, tick_lfo} <= 5'h00;
    {tx_start_evt, rx_stop_evt, wake_start, enter_standby} <= 4'h0;
    {detect_no_card, global_clr, wake_stop} <= 3'h0;
    mode_start <= 4'h0;
    #1;
  endtask

  // repeated pulses
  task automatic ticks(input int s, input int n);
    for (int k = 0; k < n; k++) drive(s, 8'h00);
  endtask

  // bounded wait for a flag (0..3) or for leaving standby (4)
  task automatic wait_hi(input int s);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 8 && !hit; k++) begin
      hit = (s < 4) ? (timer_irq_flag[s] === 1'b1) : (standby === 1'b0);
      if (!hit) begin
        @(posedge clk_sys);
        #1;
      end
    end
    if (!hit) begin
      n_errors++;
      $display("Error at %0t: wait on %h ran out", $time, s);
      end_sim();
    end else begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // build one timer setup
  function automatic rtu_pkg::rtu_cfg_s mk(input logic [1:0] sel,
      input logic ar, input logic ie, input logic st, input logic sp,
      input logic [15:0] rl);
    mk = '{clk_sel: sel, auto_reload_enable: ar, irq_enable: ie,
           start_on_tx: st, stop_on_rx: sp,
           reload_high_byte: rl[15:8], reload_low_byte: rl[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {tick_13m56, tick_212k, tick_lfo, ctrl_wr, flag_wr} = 5'h00;
    {global_clr, tx_start_evt, rx_stop_evt, wake_start} = 4'h0;
    {wake_stop, enter_standby, detect_no_card} = 3'h0;
    {wake_auto_reload_enable, auto_standby_wake} = 2'h0;
    ctrl_wdata = 8'h00;
    flag_wdata = 8'h00;
    mode_start = 4'h0;
    irq_pin_enable = 1'b1;
    wake_reload = 16'h0000;
    tmr_cfg = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    tmr_cfg[0] <= mk(rtu_pkg::SEL_13M56, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0003);
    tmr_cfg[1] <= mk(rtu_pkg::SEL_212K, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0001);
    tmr_cfg[2] <= mk(rtu_pkg::SEL_13M56, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0100);
    tmr_cfg[3] <= mk(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 16'hffff);
    @(posedge clk_sys);
    #1;
    // after reset everything is idle
    chk({timer_running, timer_irq_flag}, 16'h0000);
    chk({irq_pin, irq_status, global_irq_flag, standby}, 16'h0000);
    chk(count_value[0], 16'h0000);
    $display("test reset done");

    // one-shot time-out on the fast carrier tick
    drive(CW, 8'h11);
    chk(timer_running, 4'h1);
    chk(count_value[0], 16'h0003);
    ticks(T13, 3);
    chk(count_value[0], 16'h0000);
    chk(timer_irq_flag, 4'h0);
    drive(T13, 8'h00);
    wait_hi(0);
    chk(timer_irq_flag, 4'h1);
    chk(timer_running, 4'h0);
    chk({irq_status, irq_pin}, 2'h3);
    chk(global_irq_flag, 1'b1);
    ticks(T13, 2);
    chk(count_value[0], 16'h0000);
    $display("test timeout done");

    // host flag writes and global clear
    drive(FW, 8'h01);
    chk(timer_irq_flag, 4'h0);
    drive(GCL, 8'h00);
    chk(global_irq_flag, 1'b0);
    drive(FW, 8'h88);
    chk(timer_irq_flag, 4'h8);
    drive(FW, 8'h08);
    @(posedge clk_sys);
    #1;
    chk({timer_irq_flag, irq_status}, 5'h00);
    $display("test flags done");

    // periodic trigger started from the mode start bit
    drive(MS, 8'h02);
    chk(timer_running, 4'h2);
    chk(count_value[1], 16'h0001);
    ticks(T13, 2);
    chk(count_value[1], 16'h0001);
    for (int p = 0; p < 2; p++) begin
      ticks(T212, 2);
      wait_hi(1);
      chk(count_value[1], 16'h0001);
      chk(timer_running, 4'h2);
      drive(FW, 8'h02);
    end
    drive(CW, 8'h20);
    chk(timer_running, 4'h0);
    $display("test periodic done");

    // stop watch between transmitter and receiver events
    drive(TXE, 8'h00);
    chk(timer_running, 4'h4);
    chk(count_value[2], 16'h0100);
    ticks(T13, 5);
    drive(RXE, 8'h00);
    chk(timer_running, 4'h0);
    ticks(T13, 2);
    chk(count_value[2], 16'h00fb);
    chk(timer_irq_flag, 4'h0);
    $display("test stopwatch done");

    // immediate bit clear leaves a timer alone, pin gating
    drive(CW, 8'h88);
    chk(timer_running, 4'h8);
    chk(count_value[3], 16'hffff);
    drive(CW, 8'h00);
    chk(timer_running, 4'h8);
    drive(CW, 8'h80);
    chk(timer_running, 4'h0);
    irq_pin_enable <= 1'b0;
    drive(FW, 8'h81);
    @(posedge clk_sys);
    #1;
    chk({irq_status, irq_pin}, 2'h2);
    drive(FW, 8'h01);
    irq_pin_enable <= 1'b1;
    $display("test control done");

    // wake-up timer clocks timer 0 and leaves standby
    tmr_cfg[0] <= mk(rtu_pkg::SEL_WAKE, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0005);
    wake_reload <= 16'h0002;
    wake_auto_reload_enable <= 1'b1;
    drive(CW, 8'h11);
    drive(WST, 8'h00);
    chk(count_value[4], 16'h0002);
    ticks(T13, 2);
    chk(count_value[4], 16'h0002);
    drive(ESB, 8'h00);
    chk(standby, 1'b1);
    ticks(LOW_FREQUENCY_OSCILLATOR, 3);
    wait_hi(4);
    chk(standby, 1'b0);
    chk(count_value[0], 16'h0004);
    chk(count_value[4], 16'h0002);
    drive(DNC, 8'h00);
    chk(standby, 1'b0);
    auto_standby_wake <= 1'b1;
    drive(DNC, 8'h00);
    chk(standby, 1'b1);
    drive(WSP, 8'h00);
    ticks(LOW_FREQUENCY_OSCILLATOR, 2);
    chk(count_value[4], 16'h0002);
    $display("test wakeup done");
    end_sim();
  end
endmodule
